// ---- speech_cmd_pkg.sv ----
// shared constants and types for the wake, sleep and analog setup command link
// Behaviour
// - wake byte leaves sleep for standby
// - asleep, only wake byte is obeyed
// - sleep byte returns standby to sleep
// - duplicate mode: bytes sent twice, must match
// - duplicate mode off until wake sets it
// - analog setup is two bytes, fixed layout
// - analog setup ignored asleep, transitioning, playing
// - sleep clears held analog settings; resend after wake
// - host zeroes channel volume before analog power-up
// - analog settings default at reset and sleep
// - class bit: 0 class AB, 1 class D
// - highpass bit inserts 200Hz high-pass filter
// - fade bit makes halt fade out
// - channel busy low throughout fade-out
// - dac gain 00 off, 01 -6dB, 10 0dB
// - external gain 00 off, 01 -6dB, 10 0dB
// - host feeds external input after busy high
// - suppression bit picks line ramp durations
// - speaker uses low enable, line uses high
// - host never sets line enable with class D
// - byte units, sent only while command ready
package speech_cmd_pkg;

   localparam int unsigned CLK_NS = 8;
   localparam int unsigned CMD_PROC_NS = 1000;
   localparam int unsigned WAKE_NS = 2000;
   localparam int unsigned SLEEP_NS = 2000;
   localparam int unsigned CMD_PROC_CYC = (CMD_PROC_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SLEEP_CYC = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SCLK_HALF_CYC = 10;
   localparam int unsigned HOST_GUARD_CYC = 16;

   localparam logic [7:0] SLEEP_CMD = 8'h20;
   localparam logic [5:0] ANALOG_PREFIX = 6'h01;
   localparam int unsigned DUP_BIT = 0;
   localparam int unsigned AMP_CLASS_BIT = 1;
   localparam int unsigned HIGHPASS_BIT = 0;
   localparam int unsigned FADE_BIT = 7;
   localparam int unsigned DAC_GAIN_LSB = 5;
   localparam int unsigned EXT_GAIN_LSB = 3;
   localparam int unsigned LINE_PWR_BIT = 2;
   localparam int unsigned SPK_PWR_BIT = 1;
   localparam int unsigned SUPPRESS_BIT = 0;

   localparam logic [1:0] REG_TX = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_CONTROL = 2'h2;

   typedef struct packed {
      logic amp_class_select;
      logic highpass_enable;
      logic fade_on_halt;
      logic [1:0] dac_gain;
      logic [1:0] ext_in_gain;
      logic line_power_enable;
      logic speaker_power_enable;
      logic click_suppress;
   } analog_t;

   localparam analog_t ANALOG_DEFAULT = 10'h000;

   typedef enum logic [1:0] {
      st_down = 2'b00,
      st_rising = 2'b01,
      st_standby = 2'b10,
      st_falling = 2'b11
   } power_state_t;

   typedef enum logic [1:0] {
      h_idle = 2'b00,
      h_wait = 2'b01,
      h_shift = 2'b10,
      h_guard = 2'b11
   } host_state_t;

endpackage

// ---- speech_device_end.sv ----
// device end: serial intake and decoding of wake, sleep and analog setup commands
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module speech_device_end #(
   parameter int unsigned PROC_CYC = speech_cmd_pkg::CMD_PROC_CYC,
   parameter int unsigned WAKE_TIME_CYC = speech_cmd_pkg::WAKE_CYC,
   parameter int unsigned SLEEP_TIME_CYC = speech_cmd_pkg::SLEEP_CYC
)(
   input wire logic clock,
   input wire logic srst,
   speech_link_if.device lk,
   input wire logic playing,
   input wire logic halt_req,
   input wire logic fade_done,
   output speech_cmd_pkg::analog_t analog,
   output logic dac_path_on,
   output logic dac_path_0db,
   output logic ext_path_on,
   output logic ext_path_0db,
   output logic line_ramp_suppressed,
   output logic awake,
   output logic dup_mode,
   output logic dup_mismatch,
   output logic fade_start
);
   import speech_cmd_pkg::*;

   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [2:0] cs_sync;
      logic [2:0] data_sync;
      logic sclk_f;
      logic cs_n_f;
      logic data_f;
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [7:0] copy;
      logic have_copy;
      logic [7:0] first;
      logic analog_pending;
      power_state_t pstate;
      logic [15:0] cnt;
      logic dup;
      analog_t analog;
      logic dac_on;
      logic dac_0db;
      logic ext_on;
      logic ext_0db;
      logic line_supp;
      logic awake;
      logic fading;
      logic fade_start;
      logic dup_mismatch;
      logic cmd_busy_n;
      logic chan_busy_n;
   } dev_t;

   dev_t q;
   dev_t d;

   // gain field to {path on, 0 dB}; only meaningful with the class AB speaker amplifier
   function automatic logic [1:0] path_gain(input logic [1:0] gain, input logic class_d);
      logic [1:0] r;
      r = 2'b00;
      if (!class_d) begin
         unique case (gain)
            2'b00: r = 2'b00;
            2'b01: r = 2'b10;
            2'b10: r = 2'b11;
            2'b11: r = 2'b11;
         endcase
      end
      return r;
   endfunction

   function automatic analog_t decode_setup(input logic [7:0] b1, input logic [7:0] b2);
      analog_t a;
      a.amp_class_select = b1[AMP_CLASS_BIT];
      a.highpass_enable = b1[HIGHPASS_BIT];
      a.fade_on_halt = b2[FADE_BIT];
      a.dac_gain = b2[DAC_GAIN_LSB +: 2];
      a.ext_in_gain = b2[EXT_GAIN_LSB +: 2];
      a.line_power_enable = b2[LINE_PWR_BIT];
      a.speaker_power_enable = b2[SPK_PWR_BIT];
      a.click_suppress = b2[SUPPRESS_BIT];
      return a;
   endfunction

   always_comb begin
      logic rise;
      logic rx_valid;
      logic exec;
      logic [7:0] rx;
      rise = 1'b0;
      rx_valid = 1'b0;
      exec = 1'b0;
      rx = 8'h00;
      d = q;
      d.fade_start = 1'b0;
      d.dup_mismatch = 1'b0;

      // three-stage pin sampling, a level counts once stages two and three agree
      d.sclk_sync = {q.sclk_sync[1:0], lk.sclk};
      d.cs_sync = {q.cs_sync[1:0], lk.cs_n};
      d.data_sync = {q.data_sync[1:0], lk.sdata};
      if (q.sclk_sync[2] == q.sclk_sync[1]) begin
         d.sclk_f = q.sclk_sync[2];
      end
      if (q.cs_sync[2] == q.cs_sync[1]) begin
         d.cs_n_f = q.cs_sync[2];
      end
      if (q.data_sync[2] == q.data_sync[1]) begin
         d.data_f = q.data_sync[2];
      end
      rise = d.sclk_f && !q.sclk_f;

      // byte assembly, msb first on rising serial clock
      if (q.cs_n_f) begin
         d.bit_cnt = 3'd0;
      end else if (rise) begin
         d.shift = {q.shift[6:0], q.data_f};
         d.bit_cnt = q.bit_cnt + 3'd1;
         if (q.bit_cnt == 3'd7) begin
            rx_valid = 1'b1;
            rx = {q.shift[6:0], q.data_f};
         end
      end

      // processing timer and power transitions
      if (q.cnt != 16'd0) begin
         d.cnt = q.cnt - 16'd1;
         if (q.cnt == 16'd1) begin
            d.cmd_busy_n = 1'b1;
            if (q.pstate == st_rising) begin
               d.pstate = st_standby;
            end
            if (q.pstate == st_falling) begin
               d.pstate = st_down;
               d.analog = ANALOG_DEFAULT;
               d.dup = 1'b0;
               d.analog_pending = 1'b0;
            end
         end
      end

      if (rx_valid) begin
         d.cmd_busy_n = 1'b0;
         d.cnt = 16'(PROC_CYC);
         if (q.dup) begin
            if (!q.have_copy) begin
               d.copy = rx;
               d.have_copy = 1'b1;
            end else begin
               d.have_copy = 1'b0;
               if (rx == q.copy) begin
                  exec = 1'b1;
               end else begin
                  d.analog_pending = 1'b0;
                  d.dup_mismatch = 1'b1;
               end
            end
         end else begin
            exec = 1'b1;
         end
      end

      if (exec) begin
         if (q.analog_pending) begin
            d.analog_pending = 1'b0;
            if (q.pstate == st_standby && !playing) begin
               d.analog = decode_setup(q.first, rx);
            end
         end else begin
            unique case (q.pstate)
               st_down: begin
                  if (rx[7:1] == 7'h00) begin
                     d.pstate = st_rising;
                     d.dup = rx[DUP_BIT];
                     d.cnt = 16'(WAKE_TIME_CYC);
                  end
               end
               st_rising, st_standby, st_falling: begin
                  if (rx[7:2] == ANALOG_PREFIX) begin
                     d.first = rx;
                     d.analog_pending = 1'b1;
                  end else if (rx == SLEEP_CMD && q.pstate == st_standby && q.chan_busy_n) begin
                     // held settings stay applied through the ramp-down, then clear
                     d.pstate = st_falling;
                     d.cnt = 16'(SLEEP_TIME_CYC);
                  end
               end
            endcase
         end
      end

      if (fade_done) begin
         d.fading = 1'b0;
      end
      if (halt_req && playing && q.analog.fade_on_halt) begin
         d.fading = 1'b1;
         d.fade_start = 1'b1;
      end
      d.chan_busy_n = !(playing || d.fading);

      {d.dac_on, d.dac_0db} = path_gain(d.analog.dac_gain, d.analog.amp_class_select);
      {d.ext_on, d.ext_0db} = path_gain(d.analog.ext_in_gain, d.analog.amp_class_select);
      d.line_supp = d.analog.line_power_enable && d.analog.click_suppress;
      d.awake = (d.pstate == st_standby);
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         q <= '0;
         q.sclk_sync <= 3'h7;
         q.cs_sync <= 3'h7;
         q.sclk_f <= 1'b1;
         q.cs_n_f <= 1'b1;
         q.pstate <= st_down;
         q.analog <= ANALOG_DEFAULT;
         q.cmd_busy_n <= 1'b1;
         q.chan_busy_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign lk.command_busy_n = q.cmd_busy_n;
   assign lk.channel_busy_n = q.chan_busy_n;
   assign analog = q.analog;
   assign dac_path_on = q.dac_on;
   assign dac_path_0db = q.dac_0db;
   assign ext_path_on = q.ext_on;
   assign ext_path_0db = q.ext_0db;
   assign line_ramp_suppressed = q.line_supp;
   assign awake = q.awake;
   assign dup_mode = q.dup;
   assign dup_mismatch = q.dup_mismatch;
   assign fade_start = q.fade_start;
endmodule
`default_nettype wire

// ---- speech_host_end.sv ----
// host end: register port to serial command sender with duplicate sending and guards
`timescale 1ns/1ps
`default_nettype none
module speech_host_end #(
   parameter int unsigned HALF_CYC = speech_cmd_pkg::SCLK_HALF_CYC,
   parameter int unsigned GUARD_CYC = speech_cmd_pkg::HOST_GUARD_CYC
)(
   input wire logic clock,
   input wire logic srst,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   speech_link_if.host lk
);
   import speech_cmd_pkg::*;

   typedef struct packed {
      logic [2:0] busy_sync;
      logic [2:0] chan_sync;
      logic busy_f;
      logic chan_f;
      host_state_t hstate;
      logic [7:0] tx;
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [7:0] div;
      logic resend;
      logic dup;
      logic vol_zeroed;
      logic analog_second;
      logic class_d;
      logic refused;
      logic sclk;
      logic cs_n;
      logic sdata;
      logic [7:0] rdata;
   } host_t;

   host_t q;
   host_t d;

   always_comb begin
      logic bad;
      bad = 1'b0;
      d = q;
      d.busy_sync = {q.busy_sync[1:0], lk.command_busy_n};
      d.chan_sync = {q.chan_sync[1:0], lk.channel_busy_n};
      if (q.busy_sync[2] == q.busy_sync[1]) begin
         d.busy_f = q.busy_sync[2];
      end
      if (q.chan_sync[2] == q.chan_sync[1]) begin
         d.chan_f = q.chan_sync[2];
      end

      d.rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            REG_TX: d.rdata = q.tx;
            REG_STATUS: d.rdata = {3'h0, q.refused, q.dup, q.chan_f, q.busy_f, q.hstate == h_idle};
            REG_CONTROL: d.rdata = {7'h00, q.vol_zeroed};
            default: d.rdata = 8'h00;
         endcase
      end
      if (wr && addr == REG_CONTROL) begin
         d.vol_zeroed = wdata[0];
      end

      if (q.analog_second) begin
         bad = (q.class_d && wdata[LINE_PWR_BIT])
            || (!q.vol_zeroed && (wdata[LINE_PWR_BIT] || wdata[SPK_PWR_BIT]));
      end
      if (wr && addr == REG_TX) begin
         if (q.hstate != h_idle || bad) begin
            d.refused = 1'b1;
         end else begin
            d.refused = 1'b0;
            d.tx = wdata;
            d.resend = q.dup;
            d.hstate = h_wait;
            d.analog_second = !q.analog_second && wdata[7:2] == ANALOG_PREFIX;
            if (!q.analog_second) begin
               d.class_d = wdata[AMP_CLASS_BIT];
               if (wdata[7:1] == 7'h00) begin
                  d.dup = wdata[DUP_BIT];
               end
               if (wdata == SLEEP_CMD) begin
                  d.dup = 1'b0;
               end
            end
         end
      end

      unique case (q.hstate)
         h_idle: begin
         end
         h_wait: begin
            if (q.busy_f) begin
               d.hstate = h_shift;
               d.cs_n = 1'b0;
               d.sclk = 1'b0;
               d.sdata = q.tx[7];
               d.shift = {q.tx[6:0], 1'b0};
               d.bit_cnt = 3'd0;
               d.div = 8'(HALF_CYC);
            end
         end
         h_shift: begin
            if (q.div != 8'd0) begin
               d.div = q.div - 8'd1;
            end else if (!q.sclk) begin
               d.sclk = 1'b1;
               d.div = 8'(HALF_CYC);
            end else if (q.bit_cnt == 3'd7) begin
               d.cs_n = 1'b1;
               d.hstate = h_guard;
               d.div = 8'(GUARD_CYC);
            end else begin
               d.sclk = 1'b0;
               d.sdata = q.shift[7];
               d.shift = {q.shift[6:0], 1'b0};
               d.bit_cnt = q.bit_cnt + 3'd1;
               d.div = 8'(HALF_CYC);
            end
         end
         h_guard: begin
            if (q.div != 8'd0) begin
               d.div = q.div - 8'd1;
            end else if (q.resend) begin
               d.resend = 1'b0;
               d.hstate = h_wait;
            end else begin
               d.hstate = h_idle;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         q <= '0;
         q.hstate <= h_idle;
         q.sclk <= 1'b1;
         q.cs_n <= 1'b1;
         // ready and channel levels start at their idle high so status shows no false busy after reset
         q.busy_sync <= 3'h7;
         q.chan_sync <= 3'h7;
         q.busy_f <= 1'b1;
         q.chan_f <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign lk.sclk = q.sclk;
   assign lk.cs_n = q.cs_n;
   assign lk.sdata = q.sdata;
   assign rdata = q.rdata;
endmodule
`default_nettype wire

// ---- speech_link_checker.sv ----
// assertions on the serial command link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module speech_link_checker (
   input wire logic clock,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdata,
   input wire logic command_busy_n,
   input wire logic channel_busy_n
);
   logic sclk_q;
   logic [3:0] nbits_q;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   // counts serial clock rises inside a frame
   always_ff @(posedge clock) begin
      sclk_q <= sclk;
      if (srst || cs_n) begin
         nbits_q <= 4'h0;
      end else if (sclk && !sclk_q) begin
         nbits_q <= nbits_q + 4'h1;
      end
   end
   sequence frame_open;
      $fell(cs_n);
   endsequence
   sequence frame_close;
      $rose(cs_n);
   endsequence
   chk_sclk_idle: assert property (cs_n && $past(cs_n) |-> sclk)
      else $error("serial clock not idle high");
   chk_frame_open: assert property (frame_open |-> !sclk && command_busy_n)
      else $error("frame opened wrongly or while busy");
   chk_data_stable: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdata))
      else $error("data moved while serial clock high");
   chk_byte_bits: assert property (frame_close |-> nbits_q == 4'h8)
      else $error("frame not eight bits");
   chk_busy_answer: assert property (frame_close |-> !command_busy_n)
      else $error("no busy answer to a byte");
   chk_busy_hold: assert property ($fell(command_busy_n) |-> !command_busy_n [*8])
      else $error("busy too short");
   chk_busy_ends: assert property ($fell(command_busy_n) |-> ##[1:300] command_busy_n)
      else $error("busy never ends");
   chk_guard_gap: assert property (frame_close |-> cs_n [*8])
      else $error("frames too close");
   chk_sclk_high: assert property (!cs_n && $rose(sclk) |-> sclk [*8])
      else $error("serial clock high phase short");
endmodule
`default_nettype wire

// ---- speech_link_if.sv ----
// serial command link between the host controller and the speech device
`timescale 1ns/1ps
`default_nettype none
interface speech_link_if;
   logic sclk;
   logic cs_n;
   logic sdata;
   logic command_busy_n;
   logic channel_busy_n;
   modport device (input sclk, input cs_n, input sdata, output command_busy_n, output channel_busy_n);
   modport host (output sclk, output cs_n, output sdata, input command_busy_n, input channel_busy_n);
endinterface
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for host end, device end and a bench-driven device end
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import speech_cmd_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic playing = 1'b0;
   logic halt_req = 1'b0;
   logic fade_done = 1'b0;
   logic seen_fade = 1'b0;
   logic seen_mism = 1'b0;
   logic [7:0] rdata;
   analog_t analog;
   analog_t analog2;
   logic dac_on, dac_0db, ext_on, ext_0db, supp, awake, dup_mode, fade_start, mism2;
   int n_mismatch = 0;
   int n_checks = 0;
   int m_awake = 0;
   int m_dup = 0;
   int m_ana = 0;
   speech_link_if lk();
   speech_link_if lk2();
   speech_host_end speech_host_end_inst (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .lk(lk.host));
   speech_device_end speech_device_end_inst (.clock(clock), .srst(srst), .lk(lk.device), .playing(playing),
      .halt_req(halt_req), .fade_done(fade_done), .analog(analog), .dac_path_on(dac_on), .dac_path_0db(dac_0db),
      .ext_path_on(ext_on), .ext_path_0db(ext_0db), .line_ramp_suppressed(supp), .awake(awake),
      .dup_mode(dup_mode), .dup_mismatch(), .fade_start(fade_start));
   // second device end, fed by the bench so that host faults can be made
   speech_device_end speech_device_end_inst2 (.clock(clock), .srst(srst), .lk(lk2.device), .playing(playing),
      .halt_req(halt_req), .fade_done(fade_done), .analog(analog2), .dac_path_on(), .dac_path_0db(),
      .ext_path_on(), .ext_path_0db(), .line_ramp_suppressed(), .awake(), .dup_mode(),
      .dup_mismatch(mism2), .fade_start());
   speech_link_checker speech_link_checker_inst (.clock(clock), .srst(srst), .sclk(lk.sclk), .cs_n(lk.cs_n),
      .sdata(lk.sdata), .command_busy_n(lk.command_busy_n), .channel_busy_n(lk.channel_busy_n));
   initial begin
      lk2.sclk = 1'b1;
      lk2.cs_n = 1'b1;
      lk2.sdata = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      if (fade_start) seen_fade <= 1'b1;
      if (mism2) seen_mism <= 1'b1;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_ready();
      logic [7:0] s;
      for (int i = 0; i < 1000; i++) begin
         rd_reg(REG_STATUS, s);
         if (s[0] && s[1]) break;
      end
      check(s[1:0], 2'b11);
   endtask
   task automatic send(input logic [7:0] b);
      wr_reg(REG_TX, b);
      wait_ready();
   endtask
   task automatic setup(input logic [7:0] b1, input logic [7:0] b2);
      send(b1);
      send(b2);
      if (m_awake != 0 && !playing) m_ana = {b1[1:0], b2};
   endtask
   task automatic cmp_all();
      logic [9:0] a;
      a = m_ana[9:0];
      check(analog, a);
      check({dac_on, dac_0db}, {!a[9] && a[6:5] != 2'h0, !a[9] && a[6]});
      check({ext_on, ext_0db}, {!a[9] && a[4:3] != 2'h0, !a[9] && a[4]});
      check(supp, a[2] & a[0]);
      check({awake, dup_mode}, {m_awake[0], m_dup[0]});
   endtask
   task automatic bang(input logic [7:0] b);
      @(posedge clock);
      lk2.cs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         lk2.sclk <= 1'b0;
         lk2.sdata <= b[i];
         repeat (10) @(posedge clock);
         lk2.sclk <= 1'b1;
         repeat (10) @(posedge clock);
      end
      lk2.cs_n <= 1'b1;
      lk2.sdata <= ~b[0];
      repeat (20) @(posedge clock);
      for (int i = 0; i < 400 && lk2.command_busy_n !== 1'b1; i++) @(posedge clock);
      check(lk2.command_busy_n, 1'b1);
   endtask
   initial begin
      #600000;
      n_mismatch++;
      conclude();
   end
   initial begin
      logic [7:0] s;
      logic [7:0] b1;
      logic [7:0] b2;
      void'($urandom(23));
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      rd_reg(REG_STATUS, s);
      check(s, 8'h07);
      cmp_all();
      rd_reg(2'h3, s);
      check(s, 8'h00);
      wr_reg(REG_CONTROL, 8'h01);
      rd_reg(REG_CONTROL, s);
      check(s, 8'h01);
      send(SLEEP_CMD);
      setup(8'h04, 8'h12);
      cmp_all();
      send(8'h00);
      m_awake = 1;
      cmp_all();
      setup(8'h04, 8'h2b);
      cmp_all();
      playing <= 1'b1;
      @(posedge clock);
      halt_req <= 1'b1;
      @(posedge clock);
      halt_req <= 1'b0;
      playing <= 1'b0;
      repeat (4) @(posedge clock);
      check({seen_fade, lk.channel_busy_n}, 2'b01);
      for (int i = 0; i < 4; i++) begin
         b1 = 8'h04 | 8'($urandom % 4);
         b2 = 8'($urandom);
         if (b2[6:5] == 2'h3) b2[6] = 1'b0;
         if (b2[4:3] == 2'h3) b2[4] = 1'b0;
         if (b1[1]) b2[2] = 1'b0;
         setup(b1, b2);
         cmp_all();
      end
      send(8'h06);
      wr_reg(REG_TX, 8'h04);
      wr_reg(REG_CONTROL, 8'h00);
      wr_reg(REG_TX, 8'h02);
      rd_reg(REG_STATUS, s);
      check(s, 8'h17);
      wr_reg(REG_CONTROL, 8'h01);
      send(8'h02);
      m_ana = 10'h202;
      cmp_all();
      setup(8'h05, 8'hd6);
      cmp_all();
      playing <= 1'b1;
      setup(8'h06, 8'h00);
      cmp_all();
      @(posedge clock);
      halt_req <= 1'b1;
      @(posedge clock);
      halt_req <= 1'b0;
      playing <= 1'b0;
      repeat (20) @(posedge clock);
      check({seen_fade, lk.channel_busy_n}, 2'b10);
      fade_done <= 1'b1;
      @(posedge clock);
      fade_done <= 1'b0;
      repeat (3) @(posedge clock);
      check(lk.channel_busy_n, 1'b1);
      wr_reg(REG_TX, SLEEP_CMD);
      repeat (300) @(posedge clock);
      check({lk.command_busy_n, analog}, {1'b0, m_ana[9:0]});
      wait_ready();
      m_awake = 0;
      m_ana = 0;
      cmp_all();
      send(8'h01);
      m_awake = 1;
      m_dup = 1;
      setup(8'h04, 8'h2b);
      cmp_all();
      rd_reg(REG_STATUS, s);
      check(s[3], 1'b1);
      bang(8'h01);
      bang(8'h04);
      bang(8'h04);
      bang(8'h2b);
      bang(8'h2a);
      check({seen_mism, analog2}, {1'b1, 10'h000});
      conclude();
   end
endmodule
`default_nettype wire
